/* design/iosd_pkg.sv */
// Package of opcodes, status bit positions and timing constants
package iosd_pkg;
   // Opcodes, with bases for the register-addressed forms
   localparam logic [7:0] OP_WRITE_DATA = 8'hF0;
   localparam logic [7:0] OP_READ_DATA = 8'h70;
   localparam logic [7:0] OP_WRITE_CTRL = 8'hB0;
   localparam logic [7:0] OP_READ_CTRL = 8'h30;
   localparam logic [7:0] OP_WRITE_EXT = 8'hD4;
   localparam logic [7:0] OP_READ_EXT = 8'h54;
   localparam logic [7:0] OP_TEST_MASK_IMM = 8'hF4;
   localparam logic [7:0] OP_HALT = 8'h40;
   localparam logic [7:0] OP_NOP = 8'hC0;
   localparam logic [7:0] OP_LOAD_UPPER = 8'h92;
   localparam logic [7:0] OP_LOAD_LOWER = 8'h93;
   localparam logic [7:0] OP_STORE_UPPER = 8'h12;
   localparam logic [7:0] OP_STORE_LOWER = 8'h13;
   localparam logic [7:0] OP_LOAD_LOW_MEM = 8'h10;
   localparam logic [7:0] OP_STORE_LOW_MEM = 8'h11;
   localparam logic [7:0] OP_CLEAR_UPPER = 8'h74;
   localparam logic [7:0] OP_CLEAR_LOWER = 8'h75;
   localparam logic [7:0] OP_PRESET_UPPER = 8'h76;
   localparam logic [7:0] OP_PRESET_LOWER = 8'h77;
   localparam logic [7:0] OP_TEST_UPPER = 8'hB4;
   localparam logic [7:0] OP_TEST_LOWER = 8'hB5;
   // Condition code values
   localparam logic [1:0] CC_ZERO = 2'h0;
   localparam logic [1:0] CC_POS = 2'h1;
   localparam logic [1:0] CC_NEG = 2'h2;
   localparam logic [1:0] CC_ALL_ONES = 2'h0;
   localparam logic [1:0] CC_NOT_ALL = 2'h2;
   // Lower status byte layout
   localparam int LSB_CC_HI = 7;
   localparam int LSB_CC_LO = 6;
   localparam int LSB_BANK = 4;
   localparam int LSB_WITH_CARRY = 3;
   localparam int LSB_LOGIC_CMP = 1;
   // Upper status byte user flags
   localparam int USB_FLAG_ONE = 3;
   localparam int USB_FLAG_TWO = 4;
   localparam logic [7:0] USB_USER_MASK = 8'h18;
   // Reset values
   localparam logic [7:0] UPPER_RESET = 8'h00;
   localparam logic [7:0] LOWER_RESET = 8'h00;
   // Timing: clocks per processor cycle, extra cycles for indirection
   localparam logic [1:0] CLOCKS_PER_CYCLE = 2'h3;
   localparam logic [2:0] INDIRECT_EXTRA = 3'h2;
   localparam logic [2:0] CYC_ONE_BYTE = 3'h2;
   localparam logic [2:0] CYC_TWO_BYTE = 3'h3;
   localparam logic [2:0] CYC_MEM = 3'h4;
   // Instruction lengths in bytes
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   // Address line positions
   localparam int ADR_EXT_LINE = 13;
   localparam int ADR_DC_LINE = 14;
endpackage

/* design/iosd_cycle_timer.sv */
// Processor cycle timer: three clocks per cycle, stretched by acknowledge
`timescale 1ns/10ps
module iosd_cycle_timer (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_ack,
   output logic o_phase_last,
   output logic o_cycle_end,
   output logic o_request
);
   logic [1:0] phase_q;
   logic [1:0] phase_d;
   logic req_q;
   logic req_d;

   // Phase count and request stretch while acknowledge is late
   always_comb begin
      phase_d = phase_q;
      req_d = req_q;
      o_cycle_end = 1'b0;
      if (!i_run) begin
         phase_d = 2'h0;
         req_d = 1'b0;
      end else if (phase_q == iosd_pkg::CLOCKS_PER_CYCLE - 2'h1) begin
         if (i_ack) begin
            phase_d = 2'h0;
            req_d = 1'b0;
            o_cycle_end = 1'b1;
         end
      end else begin
         phase_d = phase_q + 2'h1;
         req_d = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         phase_q <= 2'h0;
         req_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         req_q <= req_d;
      end
   end

   assign o_phase_last = (phase_q == iosd_pkg::CLOCKS_PER_CYCLE - 2'h1);
   assign o_request = req_q;
endmodule

/* design/iosd_decoder.sv */
// I/O, halt, mask-test and status-word instruction decode and execute
// Operation
// - Register I/O opcodes are base plus register.
// - Data/control I/O one byte; extended two bytes.
// - Read sets code positive, zero or negative.
// - 40 halts into wait; C0 does nothing.
// - F4 to F7 test register under mask.
// - Mask test: all ones 00, otherwise 10.
// - 92/93 load upper/lower status from register zero.
// - 12/13 copy upper/lower status into register zero.
// - 10 loads lower status from memory, enhanced.
// - 11 stores lower status to memory, enhanced.
// - Indirect memory status forms add two cycles.
// - 74/75 clear masked status bits.
// - 76/77 preset masked status bits.
// - B4/B5 test status bits under mask.
// - Processor cycle is three clock periods.
// - Late acknowledge stretches request whole clocks.
// - Run output low while halted or paused between instructions.
// - Extended I/O puts device address low lines.
// - Address line 13 marks extended I/O.
// - Address line 14 selects data or control.
`timescale 1ns/10ps
module iosd_decoder #(
   parameter bit ENHANCED = 1'b1
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire logic [7:0] i_opcode,
   input wire logic [7:0] i_second_byte,
   input wire logic i_indirect,
   input wire logic [7:0] i_mem_data,
   input wire logic [7:0] i_bus_data,
   input wire logic i_operation_acknowledge_n,
   input wire logic i_pause_n,
   output logic o_busy,
   output logic o_done,
   output logic o_operation_request,
   output logic [14:0] o_address,
   output logic [7:0] o_data_out,
   output logic o_write,
   output logic o_mem_io_n,
   output logic o_run_wait,
   output logic [7:0] o_upper_status_byte,
   output logic [7:0] o_lower_status_byte,
   output logic [7:0] o_mem_store_data,
   output logic [1:0] o_length,
   output logic [2:0] o_cycles,
   output logic o_illegal
);
   typedef enum logic [1:0] {
      IOSD_IDLE,
      IOSD_EXEC,
      IOSD_HALT
   } iosd_state_e;

   iosd_state_e state_q, state_d;
   logic [7:0] op_q, op_d, arg_q, arg_d;
   logic [2:0] left_q, left_d;
   logic [7:0] usb_q, usb_d, lsb_q, lsb_d;
   logic [7:0] regs_q [0:6];
   logic [7:0] regs_d [0:6];
   logic busy_q, busy_d, done_q, done_d;
   logic [14:0] addr_q, addr_d;
   logic [7:0] dout_q, dout_d, mstore_q, mstore_d;
   logic wr_q, wr_d, mio_q, mio_d, run_q, run_d, ill_q, ill_d;
   logic [1:0] len_q, len_d;
   logic [2:0] cyc_q, cyc_d;
   logic cycle_end, tmr_req;
   logic [2:0] reg_idx;
   logic [7:0] sel_val;
   logic [1:0] rnum;

   iosd_cycle_timer u_timer (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_run(state_q == IOSD_EXEC),
      .i_ack(!i_operation_acknowledge_n),
      .o_phase_last(),
      .o_cycle_end(cycle_end),
      .o_request(tmr_req)
   );

   // Register index from opcode bits and bank select
   always_comb begin
      rnum = op_q[1:0];
      if (rnum == 2'h0) begin
         reg_idx = 3'h0;
      end else if (lsb_q[iosd_pkg::LSB_BANK]) begin
         reg_idx = {1'b0, rnum} + 3'h3;
      end else begin
         reg_idx = {1'b0, rnum};
      end
      sel_val = regs_q[reg_idx];
   end

   // Mask test result code
   function automatic logic [1:0] mask_cc(input logic [7:0] v,
                                          input logic [7:0] m);
      if ((v & m) == m) begin
         mask_cc = iosd_pkg::CC_ALL_ONES;
      end else begin
         mask_cc = iosd_pkg::CC_NOT_ALL;
      end
   endfunction

   // Sign/zero result code
   function automatic logic [1:0] sign_cc(input logic [7:0] v);
      if (v == 8'h00) begin
         sign_cc = iosd_pkg::CC_ZERO;
      end else if (v[7]) begin
         sign_cc = iosd_pkg::CC_NEG;
      end else begin
         sign_cc = iosd_pkg::CC_POS;
      end
   endfunction

   // Decode, sequencing and execution
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      arg_d = arg_q;
      left_d = left_q;
      usb_d = usb_q;
      lsb_d = lsb_q;
      regs_d = regs_q;
      busy_d = busy_q;
      done_d = 1'b0;
      addr_d = addr_q;
      dout_d = dout_q;
      mstore_d = mstore_q;
      wr_d = wr_q;
      mio_d = mio_q;
      run_d = run_q;
      ill_d = ill_q;
      len_d = len_q;
      cyc_d = cyc_q;
      unique case (state_q)
         IOSD_IDLE: begin
            busy_d = 1'b0;
            run_d = i_pause_n;
            if (i_instr_valid && i_pause_n) begin
               op_d = i_opcode;
               arg_d = i_second_byte;
               ill_d = 1'b0;
               busy_d = 1'b1;
               state_d = IOSD_EXEC;
               len_d = iosd_pkg::LEN_ONE;
               cyc_d = iosd_pkg::CYC_ONE_BYTE;
               mio_d = 1'b1;
               wr_d = 1'b0;
               addr_d = 15'h0000;
               unique casez (i_opcode)
                  8'b1111_00??, 8'b0111_00??, 8'b1011_00??,
                  8'b0011_00??: begin
                     mio_d = 1'b0;
                     wr_d = i_opcode[7];
                     addr_d[iosd_pkg::ADR_EXT_LINE] = 1'b0;
                     addr_d[iosd_pkg::ADR_DC_LINE] = i_opcode[6];
                  end
                  8'b1101_01??, 8'b0101_01??: begin
                     len_d = iosd_pkg::LEN_TWO;
                     cyc_d = iosd_pkg::CYC_TWO_BYTE;
                     mio_d = 1'b0;
                     wr_d = i_opcode[7];
                     addr_d[7:0] = i_second_byte;
                     addr_d[iosd_pkg::ADR_EXT_LINE] = 1'b1;
                  end
                  8'b1111_01??, 8'h74, 8'h75, 8'h76, 8'h77, 8'hB4,
                  8'hB5: begin
                     len_d = iosd_pkg::LEN_TWO;
                     cyc_d = iosd_pkg::CYC_TWO_BYTE;
                  end
                  8'h10, 8'h11: begin
                     if (ENHANCED) begin
                        len_d = iosd_pkg::LEN_THREE;
                        cyc_d = i_indirect ?
                           iosd_pkg::CYC_MEM + iosd_pkg::INDIRECT_EXTRA :
                           iosd_pkg::CYC_MEM;
                        wr_d = i_opcode[0];
                     end else begin
                        ill_d = 1'b1;
                     end
                  end
                  8'h40, 8'hC0, 8'h92, 8'h93, 8'h12, 8'h13: begin
                  end
                  default: begin
                     ill_d = 1'b1;
                  end
               endcase
               left_d = cyc_d;
            end
         end
         IOSD_EXEC: begin
            if (cycle_end) begin
               left_d = left_q - 3'h1;
               if (left_q == 3'h1) begin
                  done_d = 1'b1;
                  state_d = IOSD_IDLE;
                  busy_d = 1'b0;
                  if (!ill_q) begin
                     unique casez (op_q)
                        8'b1111_00??, 8'b1011_00??, 8'b1101_01??: begin
                           dout_d = sel_val;
                        end
                        8'b0111_00??, 8'b0011_00??,
                        8'b0101_01??: begin
                           regs_d[reg_idx] = i_bus_data;
                           lsb_d[iosd_pkg::LSB_CC_HI:iosd_pkg::LSB_CC_LO] =
                              sign_cc(i_bus_data);
                        end
                        8'b1111_01??: begin
                           lsb_d[iosd_pkg::LSB_CC_HI:iosd_pkg::LSB_CC_LO] =
                              mask_cc(sel_val, arg_q);
                        end
                        8'h40: begin
                           state_d = IOSD_HALT;
                           run_d = 1'b0;
                        end
                        8'h92: begin
                           usb_d = ENHANCED ? regs_q[0] :
                              regs_q[0] & ~iosd_pkg::USB_USER_MASK;
                        end
                        8'h93, 8'h10: begin
                           lsb_d = (op_q == iosd_pkg::OP_LOAD_LOWER) ?
                              regs_q[0] : i_mem_data;
                        end
                        8'h12: begin
                           regs_d[0] = usb_q;
                        end
                        8'h13: begin
                           regs_d[0] = lsb_q;
                        end
                        8'h11: begin
                           mstore_d = lsb_q;
                        end
                        8'h74: begin
                           usb_d = usb_q & ~arg_q;
                        end
                        8'h75: begin
                           lsb_d = lsb_q & ~arg_q;
                        end
                        8'h76: begin
                           usb_d = usb_q | (ENHANCED ? arg_q :
                              arg_q & ~iosd_pkg::USB_USER_MASK);
                        end
                        8'h77: begin
                           lsb_d = lsb_q | arg_q;
                        end
                        8'hB4: begin
                           lsb_d[iosd_pkg::LSB_CC_HI:iosd_pkg::LSB_CC_LO] =
                              mask_cc(usb_q, arg_q);
                        end
                        8'hB5: begin
                           lsb_d[iosd_pkg::LSB_CC_HI:iosd_pkg::LSB_CC_LO] =
                              mask_cc(lsb_q, arg_q);
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            end
         end
         IOSD_HALT: begin
            run_d = 1'b0;
         end
         default: begin
            state_d = IOSD_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_q <= IOSD_IDLE;
         op_q <= 8'h00;
         arg_q <= 8'h00;
         left_q <= 3'h0;
         usb_q <= iosd_pkg::UPPER_RESET;
         lsb_q <= iosd_pkg::LOWER_RESET;
         for (int i = 0; i < 7; i++) begin
            regs_q[i] <= 8'h00;
         end
         busy_q <= 1'b0;
         done_q <= 1'b0;
         addr_q <= 15'h0000;
         dout_q <= 8'h00;
         mstore_q <= 8'h00;
         wr_q <= 1'b0;
         mio_q <= 1'b1;
         run_q <= 1'b1;
         ill_q <= 1'b0;
         len_q <= 2'h0;
         cyc_q <= 3'h0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         arg_q <= arg_d;
         left_q <= left_d;
         usb_q <= usb_d;
         lsb_q <= lsb_d;
         regs_q <= regs_d;
         busy_q <= busy_d;
         done_q <= done_d;
         addr_q <= addr_d;
         dout_q <= dout_d;
         mstore_q <= mstore_d;
         wr_q <= wr_d;
         mio_q <= mio_d;
         run_q <= run_d;
         ill_q <= ill_d;
         len_q <= len_d;
         cyc_q <= cyc_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_operation_request = tmr_req;
   assign o_address = addr_q;
   assign o_data_out = dout_q;
   assign o_write = wr_q;
   assign o_mem_io_n = mio_q;
   assign o_run_wait = run_q;
   assign o_upper_status_byte = usb_q;
   assign o_lower_status_byte = lsb_q;
   assign o_mem_store_data = mstore_q;
   assign o_length = len_q;
   assign o_cycles = cyc_q;
   assign o_illegal = ill_q;
endmodule

/* tb/iosd_decoder_checker.sv */
// Checker of request timing, decoded lengths and run status
`timescale 1ns/10ps
module iosd_decoder_checker #(
   parameter bit ENHANCED = 1'b1
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_opcode,
   input wire logic i_indirect,
   input wire logic i_operation_acknowledge_n,
   input wire logic i_pause_n,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_operation_request,
   input wire logic [14:0] o_address,
   input wire logic o_mem_io_n,
   input wire logic o_run_wait,
   input wire logic [1:0] o_length,
   input wire logic [2:0] o_cycles
);
   logic [7:0] busy_cnt_q;
   logic [7:0] busy_cnt_d;
   // Clocks spent busy in the current instruction
   always_comb begin
      busy_cnt_d = o_busy ? busy_cnt_q + 8'h01 : 8'h00;
   end
   always_ff @(posedge i_clock) begin
      busy_cnt_q <= i_rst ? 8'h00 : busy_cnt_d;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Extended transfer taken
   sequence s_take_ext;
      $rose(o_busy) ##0 (($past(i_opcode) & 8'h7C) == 8'h54);
   endsequence
   a_req_held: assert property (o_operation_request &&
      i_operation_acknowledge_n |=> o_operation_request)
      else $error("request dropped before acknowledge");
   a_req_ack_drop: assert property (o_operation_request &&
      $past(o_operation_request) && !i_operation_acknowledge_n
      |=> !o_operation_request) else $error("request not ended");
   a_len_ext: assert property (s_take_ext |->
      o_length == iosd_pkg::LEN_TWO && o_cycles == iosd_pkg::CYC_TWO_BYTE)
      else $error("extended length wrong");
   a_len_io: assert property ($rose(o_busy) &&
      ($past(i_opcode) & 8'h3C) == 8'h30 |-> o_length == iosd_pkg::LEN_ONE
      && o_cycles == iosd_pkg::CYC_ONE_BYTE) else $error("io length wrong");
   a_ind_cycles: assert property ($rose(o_busy) &&
      $past(i_opcode) == iosd_pkg::OP_LOAD_LOW_MEM && $past(i_indirect)
      |-> o_cycles == 3'h6) else $error("indirect cycles wrong");
   a_addr_ext: assert property (o_operation_request &&
      !o_mem_io_n |-> o_address[13] == (o_length == iosd_pkg::LEN_TWO))
      else $error("extended line wrong");
   a_halt_run: assert property ($rose(o_busy) &&
      $past(i_opcode) == iosd_pkg::OP_HALT |-> ##[1:20] !o_run_wait)
      else $error("halt kept running");
   a_pause_run: assert property (!i_pause_n && !o_busy
      |-> ##[1:3] !o_run_wait) else $error("pause kept running");
   a_busy_span: assert property ($fell(o_busy) |->
      busy_cnt_q >= {5'h00, o_cycles} * 8'h03) else $error("too short");
   a_done_pulse: assert property (o_done |=> !o_done)
      else $error("done longer than one clock");
endmodule

bind iosd_decoder iosd_decoder_checker #(.ENHANCED(ENHANCED)) u_chk (
   .i_clock(i_clock),
   .i_rst(i_rst),
   .i_opcode(i_opcode),
   .i_indirect(i_indirect),
   .i_operation_acknowledge_n(i_operation_acknowledge_n),
   .i_pause_n(i_pause_n),
   .o_busy(o_busy),
   .o_done(o_done),
   .o_operation_request(o_operation_request),
   .o_address(o_address),
   .o_mem_io_n(o_mem_io_n),
   .o_run_wait(o_run_wait),
   .o_length(o_length),
   .o_cycles(o_cycles)
);

/* tb/iosd_bus_model.sv */
// Memory and I/O devices answering requests, promptly or late
`timescale 1ns/10ps
module iosd_bus_model (
   input wire logic i_clock,
   input wire logic i_request,
   input wire logic i_busy,
   input wire logic [3:0] i_delay,
   input wire logic [7:0] i_read_value,
   input wire logic [7:0] i_mem_value,
   output logic o_ack_n,
   output logic [7:0] o_bus_data,
   output logic [7:0] o_mem_data
);
   logic [3:0] wait_q;
   logic [3:0] wait_d;
   // Clocks the present request has waited
   always_comb begin
      wait_d = i_request ? wait_q + 4'h1 : 4'h0;
   end
   always_ff @(posedge i_clock) begin
      wait_q <= wait_d;
   end
   // Acknowledge after the chosen delay
   assign o_ack_n = !(i_request && wait_q >= i_delay);
   // Data valid only during an instruction, inverted otherwise
   assign o_bus_data = i_busy ? i_read_value : ~i_read_value;
   assign o_mem_data = i_busy ? i_mem_value : ~i_mem_value;
endmodule

/* tb/iosd_decoder_bench.sv */
// Self-checking bench for the I/O and status instruction decoder
`timescale 1ns/10ps
module iosd_decoder_bench;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic valid = 1'b0;
   logic [7:0] opc = 8'h00;
   logic [7:0] sb = 8'h00;
   logic ind = 1'b0;
   logic pause_n = 1'b1;
   logic [7:0] rd_val = 8'h00;
   logic [7:0] mem_val = 8'h00;
   logic [3:0] delay = 4'h0;
   logic ack_n, req, busy, done, wr, mem_io_n, run_wait, illegal;
   logic [7:0] bus_data, mem_data, data_out, upper, lower, store_data;
   logic [14:0] address;
   logic [1:0] length, rn, len;
   logic [2:0] cycles, cyc;
   logic [7:0] regs [0:6];
   logic [7:0] st_ops [0:8] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'hB4,
      8'hB5, 8'h92, 8'h93, 8'hF4};
   logic [7:0] st_lo, st_up, m, v, op;
   int fail_count = 0;
   int total_checks = 0;
   int seed = 32'h06acfc77;
   int n, k;

   // Clock generation
   always #5 i_clock = ~i_clock;

   iosd_decoder #(.ENHANCED(1'b1)) dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_instr_valid(valid), .i_opcode(opc), .i_second_byte(sb),
      .i_indirect(ind), .i_mem_data(mem_data), .i_bus_data(bus_data),
      .i_operation_acknowledge_n(ack_n), .i_pause_n(pause_n),
      .o_busy(busy), .o_done(done), .o_operation_request(req),
      .o_address(address), .o_data_out(data_out), .o_write(wr),
      .o_mem_io_n(mem_io_n), .o_run_wait(run_wait),
      .o_upper_status_byte(upper), .o_lower_status_byte(lower),
      .o_mem_store_data(store_data), .o_length(length),
      .o_cycles(cycles), .o_illegal(illegal));

   iosd_bus_model u_bus (.i_clock(i_clock), .i_request(req),
      .i_busy(busy), .i_delay(delay), .i_read_value(rd_val),
      .i_mem_value(mem_val), .o_ack_n(ack_n), .o_bus_data(bus_data),
      .o_mem_data(mem_data));

   task automatic report_and_stop();
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: value %h, want %h", $time, got, exp);
      end
   endtask

   task automatic check_cnt(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         fail_count++;
         $display("unexpected at %0t: %0d clocks, want %0d", $time, got, exp);
      end
   endtask

   function automatic logic [1:0] f_cc(input logic [7:0] x);
      return (x == 8'h00) ? iosd_pkg::CC_ZERO :
         x[7] ? iosd_pkg::CC_NEG : iosd_pkg::CC_POS;
   endfunction

   function automatic logic [1:0] f_mcc(input logic [7:0] x, input logic [7:0] y);
      return ((x & y) == y) ? iosd_pkg::CC_ALL_ONES : iosd_pkg::CC_NOT_ALL;
   endfunction

   function automatic int f_idx(input logic [1:0] r);
      return (r == 2'h0) ? 0 : int'(r) + (st_lo[iosd_pkg::LSB_BANK] ? 3 : 0);
   endfunction

   // One instruction, waiting for completion under a bound
   task automatic op_run(input logic [7:0] o, input logic [7:0] s,
      input logic i, input logic [1:0] l, input logic [2:0] c);
      @(posedge i_clock);
      #1;
      valid = 1'b1;
      opc = o;
      sb = s;
      ind = i;
      @(posedge i_clock);
      #1;
      valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      if (n >= 400) begin
         fail_count++;
         $display("unexpected at %0t: instruction never completed", $time);
      end
      check_val(length, l);
      check_val(cycles, c);
      if (delay == 4'h0) check_cnt(n, 3 * c);
   endtask

   // Watchdog against a hang
   initial begin
      #300000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      st_lo = iosd_pkg::LOWER_RESET;
      st_up = iosd_pkg::UPPER_RESET;
      check_val({upper, lower}, {st_up, st_lo});
      check_val({run_wait, mem_io_n, busy}, 3'b110);
      // Data, control and extended transfers, both banks
      for (int i = 0; i < 16; i++) begin
         rn = 2'(i);
         k = i % 3;
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : (i == 2) ? 8'h80 :
            8'($random(seed));
         m = 8'($random(seed));
         rd_val = v;
         op = (k == 0) ? 8'h70 : (k == 1) ? 8'h30 : 8'h54;
         len = (k == 2) ? iosd_pkg::LEN_TWO : iosd_pkg::LEN_ONE;
         cyc = (k == 2) ? iosd_pkg::CYC_TWO_BYTE : iosd_pkg::CYC_ONE_BYTE;
         op_run(op | {6'h00, rn}, m, 1'b0, len, cyc);
         regs[f_idx(rn)] = v;
         st_lo[7:6] = f_cc(v);
         check_val(lower, st_lo);
         check_val(address[13], k == 2);
         if (k == 2) check_val(address[7:0], m);
         else check_val(address[14], op[6]);
         check_val({mem_io_n, wr}, 2'b00);
         op_run((op | 8'h80) | {6'h00, rn}, m, 1'b0, len, cyc);
         check_val(data_out, regs[f_idx(rn)]);
         check_val({mem_io_n, wr}, 2'b01);
         if (i == 7) begin
            op_run(8'h77, 8'h10, 1'b0, 2'h2, 3'h3);
            st_lo = st_lo | 8'h10;
         end
      end
      // Status masks, loads and register mask tests
      for (int i = 0; i < 27; i++) begin
         op = st_ops[i % 9];
         m = 8'($random(seed));
         rn = 2'($random(seed));
         case (op)
            8'h74: st_up = st_up & ~m;
            8'h75: st_lo = st_lo & ~m;
            8'h76: st_up = st_up | m;
            8'h77: st_lo = st_lo | m;
            8'hB4: begin
               m = m & iosd_pkg::USB_USER_MASK;
               st_lo[7:6] = f_mcc(st_up, m);
            end
            8'hB5: st_lo[7:6] = f_mcc(st_lo, m);
            8'h92: st_up = regs[0];
            8'h93: st_lo = regs[0];
            default: begin
               st_lo[7:6] = f_mcc(regs[f_idx(rn)], m);
               op = op | {6'h00, rn};
            end
         endcase
         len = (op[7:1] == 7'h49) ? 2'h1 : 2'h2;
         op_run(op, m, 1'b0, len, 3'(len) + 3'h1);
         check_val(lower, st_lo);
         check_val(upper, st_up);
      end
      op_run(iosd_pkg::OP_STORE_LOWER, 8'h00, 1'b0, 2'h1, 3'h2);
      op_run(iosd_pkg::OP_WRITE_DATA, 8'h00, 1'b0, 2'h1, 3'h2);
      check_val(data_out, st_lo);
      op_run(iosd_pkg::OP_STORE_UPPER, 8'h00, 1'b0, 2'h1, 3'h2);
      op_run(iosd_pkg::OP_NOP, 8'h00, 1'b0, 2'h1, 3'h2);
      // Undecoded opcode flags illegal and changes nothing
      op_run(8'h00, 8'h00, 1'b0, 2'h1, 3'h2);
      check_val(illegal, 1'b1);
      op_run(iosd_pkg::OP_WRITE_DATA, 8'h00, 1'b0, 2'h1, 3'h2);
      check_val(data_out, st_up);
      check_val(illegal, 1'b0);
      check_val(lower, st_lo);
      // Memory forms, direct and indirect
      for (int i = 0; i < 4; i++) begin
         cyc = i[0] ? 3'h6 : 3'h4;
         op_run(8'h11, 8'($random(seed)), i[0], 2'h3, cyc);
         check_val(store_data, st_lo);
         mem_val = 8'($random(seed));
         op_run(8'h10, 8'($random(seed)), i[0], 2'h3, cyc);
         st_lo = mem_val;
         check_val(lower, st_lo);
      end
      // Late acknowledge stretches the instruction
      delay = 4'h3;
      rd_val = 8'h85;
      op_run(8'h70, 8'h00, 1'b0, 2'h1, 3'h2);
      st_lo[7:6] = iosd_pkg::CC_NEG;
      check_val(lower, st_lo);
      // Two cycles, each stretched by two clocks of late acknowledge
      check_cnt(n, 10);
      delay = 4'h0;
      // Pause refuses new work and drops run
      pause_n = 1'b0;
      valid = 1'b1;
      opc = 8'h70;
      repeat (4) @(posedge i_clock);
      #1;
      check_val({run_wait, busy}, 2'b00);
      valid = 1'b0;
      pause_n = 1'b1;
      repeat (3) @(posedge i_clock);
      #1;
      check_val(run_wait, 1'b1);
      // Halt holds until reset
      opc = iosd_pkg::OP_HALT;
      valid = 1'b1;
      @(posedge i_clock);
      #1;
      valid = 1'b0;
      repeat (20) @(posedge i_clock);
      #1;
      check_val(run_wait, 1'b0);
      rd_val = 8'h00;
      opc = 8'h70;
      valid = 1'b1;
      repeat (20) @(posedge i_clock);
      #1;
      valid = 1'b0;
      check_val({run_wait, lower}, {1'b0, st_lo});
      i_rst = 1'b1;
      repeat (3) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      check_val({run_wait, lower}, {1'b1, iosd_pkg::LOWER_RESET});
      report_and_stop();
   end
endmodule
